// ---- dv/csie_clock_select_bench.sv ----
// Self-checking bench for the clock select unit
`include "csie_regs.svh"
`default_nettype none
module csie_clock_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_n, hsel, hwrite, tick_event, pll_settled_in, pll_follow_in;
    logic        fallback_mode_in, wait_mode, stop_mode, special_mode, hreadyout, hresp, irq;
    logic        pll_source_choose, pll_power_on, pll_powered, pll_auto, osc_enable;
    logic        osc_low_amp, sys_clk_halt, core_clk_halt, tick_halt, tick_div_reset;
    logic        watchdog_halt, watchdog_div_reset;
    logic [7:0]  haddr, pc;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [31:0] msk [3] = '{32'h80, 32'h10, 32'h02};
    int          fails, check_count;

    csie_clock_select dut (
        .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tick_event, .pll_settled_in,
        .pll_follow_in, .fallback_mode_in, .wait_mode, .stop_mode, .special_mode, .irq,
        .pll_source_choose, .pll_power_on, .pll_powered, .pll_auto, .osc_enable,
        .osc_low_amp, .sys_clk_halt, .core_clk_halt, .tick_halt, .tick_div_reset,
        .watchdog_halt, .watchdog_div_reset
    );

    ////////////////////////////////////////////////////////////////
    // Single word transfer; entered right after a rising edge
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        haddr <= a;
        hwrite <= wr;
        hsel <= 1'b1;
        htrans <= csie_pkg::CSIE_NONSEQ;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= csie_pkg::CSIE_IDLE;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic chkr(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chks(input logic got, input logic exp);
        chkr({31'h0, got}, {31'h0, exp});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chkr(rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Event sources: tick pulse, settled toggle, fallback toggle
    task automatic ev(input int k);
        if (k == 0) begin
            tick_event <= 1'b1;
            @(posedge core_clk);
            tick_event <= 1'b0;
        end else if (k == 1) begin
            pll_settled_in <= ~pll_settled_in;
        end else begin
            fallback_mode_in <= ~fallback_mode_in;
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Clock and watchdog; the tests need well under a thousand cycles
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        cyc(5000);
        fails++;
        complete_run();
    end

    // Main sequence; status pins get six cycles to pass the synchroniser
    initial begin
        {rst_n, hsel, hwrite, tick_event, pll_settled_in, pll_follow_in} = '0;
        {fallback_mode_in, wait_mode, stop_mode, special_mode} = '0;
        {haddr, htrans, hsize, hwdata} = {8'h00, 2'h0, 3'h2, 32'h0};
        {fails, check_count} = '0;
        cyc(6);
        rst_n <= 1'b1;
        cyc(1);
        chks(osc_enable, 1'b1);
        rdc(`CSIE_ADDR_IRQEN, 32'h00);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h00);
        wr(`CSIE_ADDR_IRQEN, 32'hFF);
        rdc(`CSIE_ADDR_IRQEN, 32'h92);
        wr(8'h1C, 32'hFF);
        rdc(8'h1C, 32'h00);
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h81);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h01);
        pll_settled_in <= 1'b1;
        cyc(6);
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h80);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h81);
        cyc(2);
        chks(pll_source_choose, 1'b1);
        wr(`CSIE_ADDR_PLLCTL, 32'h00);
        rdc(`CSIE_ADDR_PLLCTL, 32'h40);
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h00);
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h80);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h01);
        pll_follow_in <= 1'b1;
        cyc(6);
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h80);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h81);
        // Stop with and without the pseudo-halt choice
        stop_mode <= 1'b1;
        cyc(3);
        chkr({30'h0, pll_source_choose, osc_enable}, 32'h0);
        stop_mode <= 1'b0;
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h01);
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'hC0);
        stop_mode <= 1'b1;
        cyc(3);
        chkr({30'h0, osc_enable, osc_low_amp}, 32'h3);
        stop_mode <= 1'b0;
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'hBF);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'hBF);
        rdc(`CSIE_ADDR_PLLCTL, 32'h60);
        chks(pll_auto, 1'b1);
        // Wait entry with every halt bit set
        wait_mode <= 1'b1;
        pc = 8'h00;
        repeat (5) begin
            @(posedge core_clk);
            pc = pc + {watchdog_div_reset, 3'h0, tick_div_reset};
        end
        chkr({24'h0, pc}, 32'h11);
        chkr({24'h0, sys_clk_halt, core_clk_halt, tick_halt, watchdog_halt, osc_low_amp,
              pll_source_choose, pll_power_on, pll_powered}, 32'hFA);
        wait_mode <= 1'b0;
        cyc(3);
        chkr({28'h0, sys_clk_halt, core_clk_halt, tick_halt, watchdog_halt}, 32'h0);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h3F);
        special_mode <= 1'b1;
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h00);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h00);
        wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h01);
        rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h01);
        special_mode <= 1'b0;
        // Each request source, enabled then masked
        wr(`CSIE_ADDR_FLAGS, 32'h92);
        foreach (msk[k]) begin
            wr(`CSIE_ADDR_IRQEN, msk[k]);
            // Synth clock chosen so the fallback entry has something to clear
            if (k == 2) wr(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h81);
            ev(k);
            cyc(8);
            chks(irq, 1'b1);
            if (k == 2) rdc(`CSIE_ADDR_FLAGS, 32'h13);
            if (k == 2) rdc(`CSIE_ADDR_CLOCK_SOURCE_SELECT, 32'h01);
            wr(`CSIE_ADDR_FLAGS, 32'h00);
            cyc(2);
            chks(irq, 1'b1);
            wr(`CSIE_ADDR_FLAGS, msk[k]);
            cyc(2);
            chks(irq, 1'b0);
            wr(`CSIE_ADDR_IRQEN, 32'h00);
            ev(k);
            cyc(8);
            chks(irq, 1'b0);
            bus(`CSIE_ADDR_FLAGS, 1'b0, 32'h0);
            chkr(rd & msk[k], msk[k]);
            wr(`CSIE_ADDR_FLAGS, 32'h92);
        end
        complete_run();
    end
endmodule
`default_nettype wire

// ---- dv/csie_clock_select_chk.sv ----
// Assertion checker for the clock select unit
`default_nettype none
module csie_clock_select_chk (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        pll_settled_in,
    input wire logic        pll_follow_in,
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic        pll_source_choose,
    input wire logic        osc_enable,
    input wire logic        osc_low_amp,
    input wire logic        sys_clk_halt,
    input wire logic        core_clk_halt,
    input wire logic        tick_halt,
    input wire logic        tick_div_reset,
    input wire logic        watchdog_halt,
    input wire logic        watchdog_div_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////
    // Mode entry steps
    sequence s_stop_rise;
        !stop_mode ##1 stop_mode;
    endsequence

    // Synth clock may only appear once the loop reports stable
    property p_select_guard;
        $rose(pll_source_choose) |-> pll_settled_in || pll_follow_in;
    endproperty

    // Divider reset lasts one cycle inside the halt
    property p_wdog_pulse;
        watchdog_div_reset |-> watchdog_halt ##1 !watchdog_div_reset;
    endproperty

    ////////////////////////////////////////////////////////////////
    // Bus answers at once; upper read bytes always zero
    bus_ready_a: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
        else $error("bus answer not ready or not okay");
    select_guard_a: assert property (p_select_guard)
        else $error("synth clock chosen while unstable");
    stop_clear_a: assert property (s_stop_rise |-> ##2 !pll_source_choose)
        else $error("synth clock kept after stop entry");
    osc_off_a: assert property (!osc_enable |-> $past(stop_mode))
        else $error("oscillator off outside stop");
    sys_halt_a: assert property (sys_clk_halt |-> $past(wait_mode))
        else $error("system clocks halted outside wait");
    low_amp_a: assert property (osc_low_amp |-> $past(stop_mode) || $past(wait_mode))
        else $error("low amplitude outside stop or wait");
    core_halt_a: assert property (core_clk_halt |-> $past(wait_mode))
        else $error("core clock halted outside wait");
    tick_pulse_a: assert property (tick_div_reset |-> tick_halt ##1 !tick_div_reset)
        else $error("tick divider reset not a single pulse");
    wdog_pulse_a: assert property (p_wdog_pulse)
        else $error("watchdog divider reset not a single pulse");
endmodule

bind csie_clock_select csie_clock_select_chk u_chk (
    .core_clk, .rst_n, .hreadyout, .hresp, .hrdata, .pll_settled_in, .pll_follow_in,
    .wait_mode, .stop_mode, .pll_source_choose, .osc_enable, .osc_low_amp, .sys_clk_halt,
    .core_clk_halt, .tick_halt, .tick_div_reset, .watchdog_halt, .watchdog_div_reset
);
`default_nettype wire

// ---- hw/csie_clock_select.sv ----
// Clock select and interrupt enable logic of the clock and reset unit
// Operation
// - Tick request only when tick enable set
// - Settle request while settle flag and enable
// - Fallback request while fallback flag and enable
// - Interrupt enable register readable and writable anytime
// - Ignore PLL select when PLL unstable
// - Clear PLL select on fallback, stop, and wait when PLL halt in wait set
// - Select crystal or synth clock; bus half
// - Pseudo-halt keeps oscillator at low amplitude
// - Halt system clocks in wait when set
// - Low amplitude in wait when bit set
// - PLL powered down in wait, reselect after
// - Force automatic bandwidth while PLL halts
// - Stop core clock in wait when set
// - Stop and reset tick dividers on wait
// - Stop and reset watchdog dividers on wait
// - Watchdog bit write once in normal modes
// - Change flags set by hardware, cleared writing one
// - Settled and follow read zero in fallback
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "csie_regs.svh"
`default_nettype none
module csie_clock_select #(
    parameter int ADDR_W = 8
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              tick_event,
    input  wire logic              pll_settled_in,
    input  wire logic              pll_follow_in,
    input  wire logic              fallback_mode_in,
    input  wire logic              wait_mode,
    input  wire logic              stop_mode,
    input  wire logic              special_mode,
    output logic                   irq,
    output logic                   pll_source_choose,
    output logic                   pll_power_on,
    output logic                   pll_powered,
    output logic                   pll_auto,
    output logic                   osc_enable,
    output logic                   osc_low_amp,
    output logic                   sys_clk_halt,
    output logic                   core_clk_halt,
    output logic                   tick_halt,
    output logic                   tick_div_reset,
    output logic                   watchdog_halt,
    output logic                   watchdog_div_reset
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    ////////////////////////////////////////////////////////////////////////

    logic [2:0] pin_in;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] stat_q;

    assign pin_in = {fallback_mode_in, pll_follow_in, pll_settled_in};

    // Three stages; value moves only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[g]   <= 1'b0;
                    s2_q[g]   <= 1'b0;
                    s3_q[g]   <= 1'b0;
                    stat_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_in[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        stat_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    ////////////////////////////////////////////////////////////////////////

    logic [ADDR_W-1:0] addr_q;
    logic              wr_q;
    logic              take;
    logic [7:0]        wd;
    logic              wen_flg;
    logic              wen_ie;
    logic              wen_cs;
    logic              wen_pc;

    // Zero wait states, so every address phase is taken at once
    assign take = hsel & hready & htrans[1];
    assign wd   = hwdata[7:0];

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
        hit = (a == ADDR_W'(r));
    endfunction

    assign wen_flg = wr_q & hit(addr_q, `CSIE_ADDR_FLAGS);
    assign wen_ie  = wr_q & hit(addr_q, `CSIE_ADDR_IRQEN);
    assign wen_cs  = wr_q & hit(addr_q, `CSIE_ADDR_CLOCK_SOURCE_SELECT);
    assign wen_pc  = wr_q & hit(addr_q, `CSIE_ADDR_PLLCTL);

    // Address phase capture; hsize ignored, word access only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            wr_q   <= 1'b0;
        end else begin
            addr_q <= haddr;
            wr_q   <= take & hwrite;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status, change flags and mode edges
    ////////////////////////////////////////////////////////////////////////

    logic settled;
    logic follow;
    logic fb_mode;
    logic settled_p_q;
    logic fb_p_q;
    logic wait_p_q;
    logic stop_p_q;
    logic wait_rise;
    logic stop_rise;
    logic fb_rise;
    logic tick_flag_q;
    logic set_chg_q;
    logic fb_chg_q;

    // Loop status hidden during fallback mode
    assign settled = stat_q[0] & ~stat_q[2];
    assign follow  = stat_q[1] & ~stat_q[2];
    assign fb_mode = stat_q[2];

    assign wait_rise = wait_mode & ~wait_p_q;
    assign stop_rise = stop_mode & ~stop_p_q;
    assign fb_rise   = fb_mode & ~fb_p_q;

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            settled_p_q <= 1'b0;
            fb_p_q      <= 1'b0;
            wait_p_q    <= 1'b0;
            stop_p_q    <= 1'b0;
            tick_flag_q <= 1'b0;
            set_chg_q   <= 1'b0;
            fb_chg_q    <= 1'b0;
        end else begin
            settled_p_q <= settled;
            fb_p_q      <= fb_mode;
            wait_p_q    <= wait_mode;
            stop_p_q    <= stop_mode;
            tick_flag_q <= tick_event
                | (tick_flag_q & ~(wen_flg & wd[`CSIE_FLG_TICK]));
            set_chg_q   <= (settled ^ settled_p_q)
                | (set_chg_q & ~(wen_flg & wd[`CSIE_FLG_SETCHG]));
            fb_chg_q    <= (fb_mode ^ fb_p_q)
                | (fb_chg_q & ~(wen_flg & wd[`CSIE_FLG_FBCHG]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    ////////////////////////////////////////////////////////////////////////

    csie_pkg::csie_reg8_t ie_q;
    csie_pkg::csie_reg8_t cs_q;
    csie_pkg::csie_reg8_t cs_d;
    logic                 auto_q;
    logic                 pwron_q;
    logic                 wd_lock_q;
    logic                 pll_halt_in_wait;
    logic                 pll_ok;
    logic                 sel_clr;
    logic                 sel_d;
    logic                 wdog_d;

    // Reset image of the loop control word; a literal cannot be bit-selected
    localparam csie_pkg::csie_reg8_t PC_RST = `CSIE_RST_PLLCTL;

    assign pll_halt_in_wait = cs_q[`CSIE_CS_PLL_HALT_IN_WAIT];

    // Unstable loop blocks the select: settled in auto, follow otherwise
    assign pll_ok  = auto_q ? settled : follow;
    assign sel_clr = fb_rise | stop_rise | (wait_rise & pll_halt_in_wait);
    assign sel_d   = sel_clr ? 1'b0
                   : wen_cs ? (wd[`CSIE_CS_PLL_SOURCE_CHOOSE] & pll_ok)
                   : cs_q[`CSIE_CS_PLL_SOURCE_CHOOSE];
    // Only first write after reset lands outside special modes
    assign wdog_d  = (wen_cs & (special_mode | ~wd_lock_q))
                   ? wd[`CSIE_CS_WDOGW] : cs_q[`CSIE_CS_WDOGW];
    assign cs_d    = {sel_d, wen_cs ? wd[6:1] : cs_q[6:1], wdog_d};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_q      <= `CSIE_RST_IRQEN;
            cs_q      <= `CSIE_RST_CLOCK_SOURCE_SELECT;
            auto_q    <= PC_RST[`CSIE_PC_AUTO];
            pwron_q   <= PC_RST[`CSIE_PC_PWRON];
            wd_lock_q <= 1'b0;
        end else begin
            if (wen_ie) begin
                ie_q <= wd & `CSIE_IE_MASK;
            end
            cs_q <= cs_d;
            if (wen_cs && !special_mode) begin
                wd_lock_q <= 1'b1;
            end
            // Auto held at one while the PLL halt in wait bit is set
            if (cs_d[`CSIE_CS_PLL_HALT_IN_WAIT]) begin
                auto_q <= 1'b1;
            end else if (wen_pc) begin
                auto_q <= wd[`CSIE_PC_AUTO];
            end
            // Power bit frozen while the loop drives the clocks
            if (wen_pc && !cs_q[`CSIE_CS_PLL_SOURCE_CHOOSE]) begin
                pwron_q <= wd[`CSIE_PC_PWRON];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and outputs
    ////////////////////////////////////////////////////////////////////////

    csie_pkg::csie_reg8_t flg_rd;
    csie_pkg::csie_reg8_t rd;

    assign flg_rd = {tick_flag_q, 2'h0, set_chg_q, settled, follow, fb_chg_q, fb_mode};

    // Unmapped addresses read zero and still answer OKAY
    assign rd = hit(haddr, `CSIE_ADDR_FLAGS)  ? flg_rd
              : hit(haddr, `CSIE_ADDR_IRQEN)  ? ie_q
              : hit(haddr, `CSIE_ADDR_CLOCK_SOURCE_SELECT) ? cs_q
              : hit(haddr, `CSIE_ADDR_PLLCTL) ? {1'b0, pwron_q, auto_q, 5'h00}
              : 8'h00;

    // Every output is a flop, so effects trail their cause by one edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout          <= 1'b1;
            hresp              <= 1'b0;
            hrdata             <= 32'h00000000;
            irq                <= 1'b0;
            pll_source_choose  <= 1'b0;
            pll_power_on       <= 1'b1;
            pll_powered        <= 1'b1;
            pll_auto           <= 1'b1;
            osc_enable         <= 1'b1;
            osc_low_amp        <= 1'b0;
            sys_clk_halt       <= 1'b0;
            core_clk_halt      <= 1'b0;
            tick_halt          <= 1'b0;
            tick_div_reset     <= 1'b0;
            watchdog_halt      <= 1'b0;
            watchdog_div_reset <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= (take & ~hwrite) ? {24'h000000, rd} : 32'h00000000;
            irq <= (tick_flag_q & ie_q[`CSIE_IE_TICK])
                 | (set_chg_q & ie_q[`CSIE_IE_SETL])
                 | (fb_chg_q & ie_q[`CSIE_IE_FB]);
            // Bus clock is the chosen source halved downstream
            pll_source_choose <= cs_q[`CSIE_CS_PLL_SOURCE_CHOOSE];
            pll_power_on <= pwron_q;
            // Fallback runs on the loop, so it stays powered then
            pll_powered  <= fb_mode | (pwron_q & ~(wait_mode & pll_halt_in_wait));
            pll_auto     <= auto_q;
            osc_enable   <= ~(stop_mode & ~cs_q[`CSIE_CS_PSEUDO_HALT_SELECT]);
            osc_low_amp  <= (stop_mode & cs_q[`CSIE_CS_PSEUDO_HALT_SELECT])
                          | (wait_mode & cs_q[`CSIE_CS_LOW_AMPLITUDE_IN_WAIT]);
            // Tick and watchdog have their own halts, not this one
            sys_clk_halt  <= wait_mode & cs_q[`CSIE_CS_SYS_CLOCKS_HALT_IN_WAIT];
            core_clk_halt <= wait_mode & cs_q[`CSIE_CS_CORE_HALT_IN_WAIT];
            tick_halt      <= wait_mode & cs_q[`CSIE_CS_TICKW];
            tick_div_reset <= wait_rise & cs_q[`CSIE_CS_TICKW];
            watchdog_halt      <= wait_mode & cs_q[`CSIE_CS_WDOGW];
            watchdog_div_reset <= wait_rise & cs_q[`CSIE_CS_WDOGW];
        end
    end

endmodule
`default_nettype wire

// ---- inc/csie_pkg.sv ----
// Types shared by the clock select unit
`default_nettype none
package csie_pkg;
    // AHB-Lite transfer kinds
    typedef enum logic [1:0] {
        CSIE_IDLE   = 2'h0,
        CSIE_BUSY   = 2'h1,
        CSIE_NONSEQ = 2'h2,
        CSIE_SEQ    = 2'h3
    } csie_htrans_t;
    typedef logic [7:0] csie_reg8_t;
endpackage
`default_nettype wire

// ---- inc/csie_regs.svh ----
// Register offsets, field positions and reset values of the clock select unit
`ifndef CSIE_REGS_SVH
`define CSIE_REGS_SVH

// Register indices; byte address is four times the index
`define CSIE_IDX_FLAGS  8'h03
`define CSIE_IDX_IRQEN  8'h04
`define CSIE_IDX_CLOCK_SOURCE_SELECT 8'h05
`define CSIE_IDX_PLLCTL 8'h06
`define CSIE_ADDR_FLAGS  8'h0C
`define CSIE_ADDR_IRQEN  8'h10
`define CSIE_ADDR_CLOCK_SOURCE_SELECT 8'h14
`define CSIE_ADDR_PLLCTL 8'h18

// Flag and status register fields
`define CSIE_FLG_TICK   7
`define CSIE_FLG_SETCHG 4
`define CSIE_FLG_SETTLD 3
`define CSIE_FLG_FOLLOW 2
`define CSIE_FLG_FBCHG  1
`define CSIE_FLG_FBMODE 0

// Interrupt enable fields
`define CSIE_IE_TICK  7
`define CSIE_IE_SETL  4
`define CSIE_IE_FB    1
`define CSIE_IE_MASK  8'h92

// Clock select fields
`define CSIE_CS_PLL_SOURCE_CHOOSE 7
`define CSIE_CS_PSEUDO_HALT_SELECT   6
`define CSIE_CS_SYS_CLOCKS_HALT_IN_WAIT 5
`define CSIE_CS_LOW_AMPLITUDE_IN_WAIT 4
`define CSIE_CS_PLL_HALT_IN_WAIT 3
`define CSIE_CS_CORE_HALT_IN_WAIT   2
`define CSIE_CS_TICKW  1
`define CSIE_CS_WDOGW  0

// PLL control fields kept here
`define CSIE_PC_PWRON 6
`define CSIE_PC_AUTO  5

// Reset values
`define CSIE_RST_IRQEN  8'h00
`define CSIE_RST_CLOCK_SOURCE_SELECT 8'h00
`define CSIE_RST_PLLCTL 8'h60

`endif
